// [hdl/ufb_pkg.sv]
// Package with register map, field positions and sizes of the flags and baud divisor block.
package ufb_pkg;
  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [11:0] UFB_OFS_FLAGS = 12'h018;
  localparam logic [11:0] UFB_OFS_DIV_INT = 12'h024;
  localparam logic [11:0] UFB_OFS_DIV_FRAC = 12'h028;
  localparam logic [11:0] UFB_OFS_LINE_CTRL = 12'h02c;
  localparam logic [11:0] UFB_OFS_IRQ_STAT = 12'h040;
  localparam logic [11:0] UFB_OFS_IRQ_MASK = 12'h044;
  localparam logic [11:0] UFB_OFS_STATUS = 12'h048;
  // ---------------------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------------------
  localparam int UFB_BIT_TX_EMPTY = 7;
  localparam int UFB_BIT_RX_FULL = 6;
  localparam int UFB_BIT_TX_FULL = 5;
  localparam int UFB_BIT_RX_EMPTY = 4;
  localparam int UFB_BIT_BUSY = 3;
  localparam int UFB_BIT_FIFO_MODE = 4;
  localparam int UFB_INT_W = 16;
  localparam int UFB_FRAC_W = 6;
  localparam int UFB_LCR_W = 8;
  localparam int UFB_IRQ_W = 4;
  localparam int UFB_IRQ_TX_DONE = 0;
  localparam int UFB_IRQ_RX_DATA = 1;
  localparam int UFB_IRQ_TX_FREE = 2;
  localparam int UFB_IRQ_RX_OVR = 3;
  localparam int UFB_FIFO_DEPTH = 16;
  localparam logic [1:0] UFB_RESP_OKAY = 2'h0;
  localparam logic [1:0] UFB_RESP_SLVERR = 2'h2;
  // Lowest divide ratio applied when the integer divisor reads zero.
  localparam logic [UFB_INT_W-1:0] UFB_DIV_MIN = 16'h0001;
endpackage

// [hdl/ufb_occ_if.sv]
// Interface carrying one occupancy counter's push, pop and level flags.
`timescale 1ns/1ps
interface ufb_occ_if;
  logic push;
  logic pop;
  logic fifo_mode;
  logic empty;
  logic full;
  logic overflow;
  modport ctr (input push, input pop, input fifo_mode, output empty, output full, output overflow);
  modport user (output push, output pop, output fifo_mode, input empty, input full, input overflow);
endinterface

// [hdl/ufb_occ.sv]
// Occupancy counter of one buffer: one entry in character mode, DEPTH entries in FIFO mode.
`timescale 1ns/1ps
module ufb_occ import ufb_pkg::*; #(
  parameter int DEPTH = UFB_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  ufb_occ_if.ctr occ
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] ONE = CW'(1);
  localparam logic [CW-1:0] FULLN = CW'(DEPTH);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] limit;
  logic do_push;
  logic do_pop;

  assign limit = occ.fifo_mode ? FULLN : ONE;
  assign do_pop = occ.pop && (cnt_r != '0);
  // A push to a full buffer is dropped and reported unless a pop frees an entry in the same cycle.
  assign do_push = occ.push && ((cnt_r < limit) || do_pop);
  assign occ.empty = (cnt_r == '0);
  assign occ.full = (cnt_r >= limit);
  assign occ.overflow = occ.push && !do_push;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (do_push && !do_pop) begin
      cnt_r <= cnt_r + ONE;
    end else if (do_pop && !do_push) begin
      cnt_r <= cnt_r - ONE;
    end
  end

  a_count_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i) cnt_r <= FULLN)
    else $error("occupancy above depth");
endmodule

// [hdl/ufb_top.sv]
// Top of the line flags and baud divisor block with its AXI4-Lite register slave.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
// How it works
// - tx_empty_flag bit 7 is one when the transmit holding register or FIFO is empty.
// - rx_full_flag bit 6 is one when receive holder occupied or FIFO full.
// - tx_full_flag bit 5 is one when transmit holder occupied or FIFO full.
// - rx_empty_flag bit 4 is one when the receive holder or FIFO is empty.
// - Busy bit 3 stays set until the whole character with stop bits is sent.
// - Busy sets once the transmit buffer holds an entry, enabled or not.
// - After reset both full flags and busy read zero, both empty flags one.
// - Integer divisor occupies bits 15:0, readable and writable, reset to zero.
// - A zero integer divisor is replaced by the minimum divide ratio of one.
// - Fractional divisor occupies bits 5:0, readable and writable, reset to zero.
// - New divisor values take effect only after the current transmit character completes.
// - Reserved bits read undefined; software writes back previous values.
// - Line control bit 4 selects FIFO mode; clear means single-entry holders.
// - Divisors are captured into the baud generator only on line control write.
module ufb_top import ufb_pkg::*; #(
  parameter int FIFO_DEPTH = UFB_FIFO_DEPTH
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [11:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [11:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic TX_PUSH_I,
  input wire logic TX_POP_I,
  input wire logic TX_CHAR_DONE_I,
  input wire logic RX_PUSH_I,
  input wire logic RX_POP_I,
  input wire logic RX_CHAR_DONE_I,
  output logic [UFB_INT_W-1:0] BAUD_INT_O,
  output logic [UFB_FRAC_W-1:0] BAUD_FRAC_O,
  output logic FIFO_MODE_O,
  output logic TX_EMPTY_O,
  output logic TX_FULL_O,
  output logic RX_EMPTY_O,
  output logic RX_FULL_O,
  output logic BUSY_O,
  output logic IRQ_O
);
  // ---------------------------------------------------------------------------
  // Buffers and transmitter activity
  // ---------------------------------------------------------------------------
  ufb_occ_if tx_if ();
  ufb_occ_if rx_if ();
  logic [UFB_LCR_W-1:0] line_control_r;
  logic fifo_mode_select;
  logic shifting_r;
  logic busy;

  assign fifo_mode_select = line_control_r[UFB_BIT_FIFO_MODE];
  assign tx_if.push = TX_PUSH_I;
  assign tx_if.pop = TX_POP_I;
  assign tx_if.fifo_mode = fifo_mode_select;
  assign rx_if.push = RX_PUSH_I;
  assign rx_if.pop = RX_POP_I;
  assign rx_if.fifo_mode = fifo_mode_select;

  ufb_occ #(.DEPTH(FIFO_DEPTH)) u_tx_occ (.clk_i(CLK_I), .rst_n_i(RST_N_I), .occ(tx_if));
  ufb_occ #(.DEPTH(FIFO_DEPTH)) u_rx_occ (.clk_i(CLK_I), .rst_n_i(RST_N_I), .occ(rx_if));

  // The shifter holds a character from its pop until the last stop bit is out.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      shifting_r <= 1'b0;
    end else if (TX_POP_I && !tx_if.empty) begin
      shifting_r <= 1'b1;
    end else if (TX_CHAR_DONE_I) begin
      shifting_r <= 1'b0;
    end
  end

  // Busy does not depend on any enable, only on buffered or shifting data.
  assign busy = !tx_if.empty || shifting_r;

  // ---------------------------------------------------------------------------
  // Registered flag outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      TX_EMPTY_O <= 1'b1;
      RX_EMPTY_O <= 1'b1;
      TX_FULL_O <= 1'b0;
      RX_FULL_O <= 1'b0;
      BUSY_O <= 1'b0;
      FIFO_MODE_O <= 1'b0;
    end else begin
      TX_EMPTY_O <= tx_if.empty;
      RX_FULL_O <= rx_if.full;
      TX_FULL_O <= tx_if.full;
      RX_EMPTY_O <= rx_if.empty;
      BUSY_O <= busy;
      FIFO_MODE_O <= fifo_mode_select;
    end
  end

  // ---------------------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------------------
  logic [11:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic wr_go;
  logic wr_hit;
  logic [UFB_INT_W-1:0] baud_divisor_integer_r;
  logic [UFB_FRAC_W-1:0] baud_divisor_fraction_r;
  logic lcr_strobe;

  function automatic logic known_addr(input logic [11:0] a);
    return (a == UFB_OFS_FLAGS) || (a == UFB_OFS_DIV_INT) || (a == UFB_OFS_DIV_FRAC) ||
      (a == UFB_OFS_LINE_CTRL) || (a == UFB_OFS_IRQ_STAT) || (a == UFB_OFS_IRQ_MASK) ||
      (a == UFB_OFS_STATUS);
  endfunction

  assign wr_go = aw_have_r && w_have_r && !S_AXI_BVALID_O;
  assign wr_hit = known_addr(aw_addr_r);
  assign lcr_strobe = wr_go && (aw_addr_r == UFB_OFS_LINE_CTRL) && w_strb_r[0];

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 12'h000;
      S_AXI_AWREADY_O <= 1'b0;
    end else if (S_AXI_AWREADY_O && S_AXI_AWVALID_I) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= {S_AXI_AWADDR_I[11:2], 2'h0};
      S_AXI_AWREADY_O <= 1'b0;
    end else if (wr_go) begin
      aw_have_r <= 1'b0;
    end else begin
      S_AXI_AWREADY_O <= !aw_have_r && !S_AXI_BVALID_O;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      S_AXI_WREADY_O <= 1'b0;
    end else if (S_AXI_WREADY_O && S_AXI_WVALID_I) begin
      w_have_r <= 1'b1;
      w_data_r <= S_AXI_WDATA_I;
      w_strb_r <= S_AXI_WSTRB_I;
      S_AXI_WREADY_O <= 1'b0;
    end else if (wr_go) begin
      w_have_r <= 1'b0;
    end else begin
      S_AXI_WREADY_O <= !w_have_r && !S_AXI_BVALID_O;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= UFB_RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O <= wr_hit ? UFB_RESP_OKAY : UFB_RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // Reserved bits are not stored, so writing back whatever was read is harmless.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      baud_divisor_integer_r <= '0;
      baud_divisor_fraction_r <= '0;
      line_control_r <= '0;
    end else if (wr_go) begin
      // The flag register has no write path, so a write there only answers OKAY.
      if (aw_addr_r == UFB_OFS_DIV_INT) begin
        if (w_strb_r[0]) baud_divisor_integer_r[7:0] <= w_data_r[7:0];
        if (w_strb_r[1]) baud_divisor_integer_r[15:8] <= w_data_r[15:8];
      end
      if (aw_addr_r == UFB_OFS_DIV_FRAC && w_strb_r[0]) begin
        baud_divisor_fraction_r <= w_data_r[UFB_FRAC_W-1:0];
      end
      if (lcr_strobe) begin
        line_control_r <= w_data_r[UFB_LCR_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Baud generator load
  // ---------------------------------------------------------------------------
  // A line control write captures both divisors and sets the load pending.
  // The load lands once no character is shifting out, so a running frame keeps
  // its bit timing. A receive start is not visible here, so a receive
  // character in flight is not waited for.
  logic load_pend_r;
  logic line_idle;
  logic [UFB_INT_W-1:0] staged_int_r;
  logic [UFB_FRAC_W-1:0] staged_frac_r;

  assign line_idle = !shifting_r;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      load_pend_r <= 1'b0;
      staged_int_r <= '0;
      staged_frac_r <= '0;
      BAUD_INT_O <= UFB_DIV_MIN;
      BAUD_FRAC_O <= '0;
    end else begin
      if (lcr_strobe) begin
        load_pend_r <= 1'b1;
        staged_int_r <= baud_divisor_integer_r;
        staged_frac_r <= baud_divisor_fraction_r;
      end else if (load_pend_r && line_idle) begin
        load_pend_r <= 1'b0;
      end
      if (load_pend_r && line_idle) begin
        BAUD_INT_O <= (staged_int_r == '0) ? UFB_DIV_MIN : staged_int_r;
        BAUD_FRAC_O <= staged_frac_r;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  logic [UFB_IRQ_W-1:0] irq_stat_r;
  logic [UFB_IRQ_W-1:0] irq_mask_r;
  logic [UFB_IRQ_W-1:0] irq_set;
  logic [UFB_IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[UFB_IRQ_TX_DONE] = shifting_r && TX_CHAR_DONE_I;
    irq_set[UFB_IRQ_RX_DATA] = RX_PUSH_I;
    irq_set[UFB_IRQ_TX_FREE] = TX_FULL_O && !tx_if.full;
    irq_set[UFB_IRQ_RX_OVR] = rx_if.overflow;
    irq_clr = '0;
    if (wr_go && aw_addr_r == UFB_OFS_IRQ_STAT && w_strb_r[0]) begin
      irq_clr = w_data_r[UFB_IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      irq_stat_r <= '0;
    end else begin
      // A set in the cycle of its clear wins, so no event is lost.
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      irq_mask_r <= '0;
    end else if (wr_go && aw_addr_r == UFB_OFS_IRQ_MASK && w_strb_r[0]) begin
      irq_mask_r <= w_data_r[UFB_IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |((irq_stat_r & ~irq_clr | irq_set) & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (S_AXI_ARADDR_I & 12'hffc)
      UFB_OFS_FLAGS: begin
        rd_word[UFB_BIT_TX_EMPTY] = TX_EMPTY_O;
        rd_word[UFB_BIT_RX_FULL] = RX_FULL_O;
        rd_word[UFB_BIT_TX_FULL] = TX_FULL_O;
        rd_word[UFB_BIT_RX_EMPTY] = RX_EMPTY_O;
        rd_word[UFB_BIT_BUSY] = BUSY_O;
      end
      UFB_OFS_DIV_INT: rd_word[UFB_INT_W-1:0] = baud_divisor_integer_r;
      UFB_OFS_DIV_FRAC: rd_word[UFB_FRAC_W-1:0] = baud_divisor_fraction_r;
      UFB_OFS_LINE_CTRL: rd_word[UFB_LCR_W-1:0] = line_control_r;
      UFB_OFS_IRQ_STAT: rd_word[UFB_IRQ_W-1:0] = irq_stat_r;
      UFB_OFS_IRQ_MASK: rd_word[UFB_IRQ_W-1:0] = irq_mask_r;
      UFB_OFS_STATUS: rd_word[UFB_INT_W-1:0] = BAUD_INT_O;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= UFB_RESP_OKAY;
    end else if (S_AXI_ARREADY_O && S_AXI_ARVALID_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= rd_word;
      S_AXI_RRESP_O <= known_addr(S_AXI_ARADDR_I & 12'hffc) ? UFB_RESP_OKAY : UFB_RESP_SLVERR;
    end else if (S_AXI_RVALID_O) begin
      if (S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end else begin
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_busy_on_data: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !tx_if.empty |=> BUSY_O) else $error("busy not set with data queued");
  a_busy_holds: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    shifting_r && !TX_CHAR_DONE_I |=> BUSY_O) else $error("busy dropped mid-frame");
  a_empty_full_excl: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !(TX_EMPTY_O && TX_FULL_O)) else $error("tx empty and full together");
  a_txfull_char: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !fifo_mode_select && !tx_if.empty |=> TX_FULL_O) else $error("tx holder not full");
  a_rxfull_char: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !fifo_mode_select && !rx_if.empty |=> RX_FULL_O) else $error("rx holder not full");
  a_rxempty_flag: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    rx_if.empty |=> RX_EMPTY_O) else $error("rx empty flag missing");
  a_reset_flags: assert property (@(posedge CLK_I)
    !RST_N_I |=> TX_EMPTY_O && RX_EMPTY_O && !TX_FULL_O && !RX_FULL_O && !BUSY_O)
    else $error("flags wrong after reset");
  a_div_nonzero: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    BAUD_INT_O != '0) else $error("zero divide ratio applied");
  a_div_no_strobe: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !load_pend_r |=> $stable(BAUD_INT_O) && $stable(BAUD_FRAC_O))
    else $error("divisor changed without line control write");
  a_div_mid_frame: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    shifting_r |=> $stable(BAUD_INT_O) && $stable(BAUD_FRAC_O))
    else $error("divisor changed mid-character");
  a_stage_on_strobe: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !lcr_strobe |=> $stable(staged_int_r) && $stable(staged_frac_r))
    else $error("divisor staged without line control write");
endmodule

// [tb/ufb_line_model.sv]
// Behavioural model of the remote transceiver that drains the transmit buffer frame by frame.
`timescale 1ns/1ps
module ufb_line_model #(
  parameter int FRAME = 40
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic tx_empty_i,
  output logic tx_pop_o,
  output logic tx_done_o
);
  logic frame_r;
  logic [7:0] cnt_r;
  // ---------------------------------------------------------------------------
  // Frame timing
  // ---------------------------------------------------------------------------
  // No pop in the cycle of a done pulse, so the lagging empty flag is never misread.
  always_ff @(posedge clk_i) begin
    tx_pop_o <= 1'b0;
    tx_done_o <= 1'b0;
    if (!rst_n_i) begin
      frame_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (frame_r) begin
      cnt_r <= cnt_r + 8'h01;
      if (cnt_r == 8'(FRAME - 1)) begin
        frame_r <= 1'b0;
        tx_done_o <= 1'b1;
      end
    end else if (run_i && !tx_empty_i && !tx_done_o) begin
      tx_pop_o <= 1'b1;
      frame_r <= 1'b1;
      cnt_r <= 8'h00;
    end
  end
endmodule

// [tb/ufb_top_tb.sv]
// Self-checking testbench of the line flags and baud divisor block.
`timescale 1ns/1ps
module ufb_top_tb;
  import ufb_pkg::*;
  localparam int DEPTH = 4;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic tx_push = 1'b0, rx_push = 1'b0, rx_pop = 1'b0, rx_done = 1'b0;
  logic tx_pop, tx_done, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] baud_int;
  logic [5:0] baud_frac;
  logic fifo_mode, tx_empty, tx_full, rx_empty, rx_full, busy, irq, irq_a;
  int miscompares = 0, checks = 0, cyc = 0;
  ufb_top #(.FIFO_DEPTH(DEPTH)) i_ufb_top (.CLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .TX_PUSH_I(tx_push),
    .TX_POP_I(tx_pop), .TX_CHAR_DONE_I(tx_done), .RX_PUSH_I(rx_push), .RX_POP_I(rx_pop),
    .RX_CHAR_DONE_I(rx_done), .BAUD_INT_O(baud_int), .BAUD_FRAC_O(baud_frac),
    .FIFO_MODE_O(fifo_mode), .TX_EMPTY_O(tx_empty), .TX_FULL_O(tx_full),
    .RX_EMPTY_O(rx_empty), .RX_FULL_O(rx_full), .BUSY_O(busy), .IRQ_O(irq));
  ufb_line_model #(.FRAME(40)) i_ufb_line_model (.clk_i(clk), .rst_n_i(rst_n), .run_i(run),
    .tx_empty_i(tx_empty), .tx_pop_o(tx_pop), .tx_done_o(tx_done));
  // ---------------------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic conclude();
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // ---------------------------------------------------------------------------
  // Bus and strobe tasks
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Holds one strobe for n cycles, so n back-to-back pushes or pops are issued.
  task automatic strobe(input int k, input int n);
    @(posedge clk);
    case (k)
      0: tx_push <= 1'b1;
      1: rx_push <= 1'b1;
      default: rx_pop <= 1'b1;
    endcase
    repeat (n) @(posedge clk);
    tx_push <= 1'b0;
    rx_push <= 1'b0;
    rx_pop <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(UFB_OFS_FLAGS, 32'h0000_0090);
    rdchk(UFB_OFS_DIV_INT, 32'h0);
    rdchk(UFB_OFS_DIV_FRAC, 32'h0);
    chk(32'(baud_int), 32'h1);
    wr(UFB_OFS_FLAGS, 32'h0000_0028);
    chk(32'(resp), 32'(UFB_RESP_OKAY));
    rdchk(UFB_OFS_FLAGS, 32'h0000_0090);
    rdchk(12'h100, 32'h0);
    chk(32'(resp), 32'(UFB_RESP_SLVERR));
    wr(UFB_OFS_DIV_INT, 32'h0000_1234);
    wr(UFB_OFS_DIV_FRAC, 32'h0000_003f);
    rdchk(UFB_OFS_DIV_INT, 32'h0000_1234);
    rdchk(UFB_OFS_DIV_FRAC, 32'h0000_003f);
    chk(32'(baud_int), 32'h1);
    wr(UFB_OFS_LINE_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk({baud_int, 10'h0, baud_frac}, 32'h1234_003f);
    wr(UFB_OFS_DIV_INT, 32'h0);
    wr(UFB_OFS_LINE_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(baud_int), 32'h1);
    // One received character fills the single holding register in character mode.
    strobe(1, 1);
    rdchk(UFB_OFS_FLAGS, 32'h0000_00c0);
    chk({30'h0, rx_full, rx_empty}, 32'h2);
    strobe(2, 1);
    // One character held while the line is stopped, then sent during a divisor change.
    strobe(0, 1);
    rdchk(UFB_OFS_FLAGS, 32'h0000_0038);
    run <= 1'b1;
    wr(UFB_OFS_DIV_INT, 32'h0000_0005);
    wr(UFB_OFS_LINE_CTRL, 32'h0);
    do @(posedge clk); while (!tx_done);
    chk({30'h0, busy, tx_empty}, 32'h3);
    chk(32'(baud_int), 32'h1);
    repeat (4) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    chk(32'(baud_int), 32'h5);
    run <= 1'b0;
    wr(UFB_OFS_LINE_CTRL, 32'h10);
    repeat (2) @(posedge clk);
    chk({31'h0, fifo_mode}, 32'h1);
    strobe(0, DEPTH - 1);
    chk({tx_empty, tx_full}, 32'h0);
    strobe(0, 1);
    rdchk(UFB_OFS_FLAGS, 32'h0000_0038);
    run <= 1'b1;
    do @(posedge clk); while (busy !== 1'b0);
    rdchk(UFB_OFS_FLAGS, 32'h0000_0090);
    wr(UFB_OFS_IRQ_STAT, 32'hf);
    strobe(1, DEPTH - 1);
    rdchk(UFB_OFS_FLAGS, 32'h0000_0080);
    strobe(1, 2);
    rx_done <= 1'b1;
    rdchk(UFB_OFS_FLAGS, 32'h0000_00c0);
    rx_done <= 1'b0;
    chk({30'h0, rx_full, rx_empty}, 32'h2);
    rdchk(UFB_OFS_IRQ_STAT, 32'ha);
    wr(UFB_OFS_IRQ_MASK, 32'hf);
    repeat (2) @(posedge clk);
    irq_a = irq;
    wr(UFB_OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_a}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    strobe(2, DEPTH);
    rdchk(UFB_OFS_FLAGS, 32'h0000_0090);
    wr(UFB_OFS_IRQ_STAT, 32'ha);
    rdchk(UFB_OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    conclude();
  end
endmodule
